// file: src/repg_pg_timer.sv
// Release delay counter for the switcher group power-good output.
`timescale 1ns/1ps
module repg_pg_timer
  import repg_pkg::*;
#(
  parameter int unsigned DELAY = PG_DELAY_CYC
) (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic run_i,
  output logic      done_o
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_reg;

  // Dropping run restarts the count at once, so a brief dip never keeps old progress.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
      done_o  <= 1'b0;
    end else if (ce_i) begin
      if (!run_i) begin
        cnt_reg <= '0;
        done_o  <= 1'b0;
      end else if (cnt_reg == CNT_W'(DELAY - 1)) begin
        done_o  <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

endmodule

// file: src/repg_pkg.sv
// Shared constants, register map and carrier types of the regulator enable and power-good block.
package repg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned PG_DELAY_MS  = 230;
  localparam int unsigned PG_DELAY_CYC = (CLK_HZ / 1000) * PG_DELAY_MS;
  localparam int          CNT_W        = 23;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the Avalon-MM slave
  // ----------------------------------------------------------------
  localparam int             ADDR_W        = 5;
  localparam logic [4:0]     ADDR_CTRL     = 5'h00;
  localparam logic [4:0]     ADDR_STATUS   = 5'h04;
  localparam logic [4:0]     ADDR_IRQ_STAT = 5'h08;
  localparam logic [4:0]     ADDR_IRQ_CLR  = 5'h0c;
  localparam logic [4:0]     ADDR_IRQ_EN   = 5'h10;
  localparam logic [31:0]    RDATA_RST     = 32'h0000_0000;

  // Control register fields.
  localparam int LIN_N        = 2;
  localparam int SW_N         = 3;
  localparam int CTRL_LIN_LSB = 0;
  localparam int CTRL_BRST_LSB = 4;

  // Status register fields.
  localparam int STAT_GOOD_LSB = 0;
  localparam int STAT_ON_LSB   = 2;
  localparam int STAT_SW_ON    = 4;
  localparam int STAT_SW_GOOD  = 5;

  // Interrupt bits.
  localparam int IRQ_W        = 4;
  localparam int IRQ_SYS_UV   = 0;
  localparam int IRQ_LOGIC_UV = 1;
  localparam int IRQ_PG_RISE  = 2;
  localparam int IRQ_PG_FALL  = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            read;
    logic            write;
    logic [4:0]      address;
    logic [31:0]     writedata;
  } repg_avs_req_t;

  typedef struct packed {
    logic            system_supply_rail_low;
    logic            logic_supply_rail_low;
    logic [1:0]      linear_reg_good;
    logic [2:0]      switcher_above_92;
  } repg_sense_t;

  localparam repg_sense_t SENSE_RST = 7'h00;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } repg_bus_state_t;

endpackage

// file: src/repg_sync.sv
// Three-stage synchroniser for pin-level inputs with agreement filter.
`timescale 1ns/1ps
module repg_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic [W-1:0]      q_o
);

  // ----------------------------------------------------------------
  // Per-bit chain
  // ----------------------------------------------------------------
  // A change is passed on only once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          q_o[g] <= 1'b0;
        end else if (ce_i) begin
          s1_reg <= d_i[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_o[g] <= s3_reg;
          end
        end
      end
    end
  endgenerate

endmodule

// file: src/repg_top.sv
// Regulator enable, lockout, discharge and power-good control with Avalon-MM registers.
//
// Behaviour
// [RULE_01] A linear regulator turns on when software writes a one to its enable bit.
// [RULE_02] A linear regulator turns off on a zero enable, logic supply undervoltage or power-down.
// [RULE_03] System supply lockout forces both linear regulators off and ignores enable writes.
// [RULE_04] A disabled linear regulator is powered down and its output discharge is switched on.
// [RULE_05] Each linear regulator has one power-good bit in the status read-back.
// [RULE_06] The linear power-good comparators are captured when the status read is addressed.
// [RULE_07] Each switcher has its own burst select bit, independent of the other two.
// [RULE_08] The three switchers are switched on and off together by the pushbutton sequencer.
// [RULE_09] The switchers are held off while the system supply is in lockout.
// [RULE_10] Group power-good shows good only when all switchers are on and in regulation.
// [RULE_11] Group power-good is released 230 ms after all switchers pass 92 percent of target.
// [RULE_12] The system pulls the open-drain group power-good up and may use it as processor reset.
// [RULE_13] Group power-good drives low at once and the delay restarts when any switcher drops.
`timescale 1ns/1ps
module repg_top #(
  parameter int unsigned PG_DELAY_CYCLES = repg_pkg::PG_DELAY_CYC
) (
  input  wire logic                  clock_i,
  input  wire logic                  nrst_i,
  input  wire logic                  ce_i,
  input  wire repg_pkg::repg_avs_req_t avs_req_i,
  output logic [31:0]                avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire repg_pkg::repg_sense_t sense_i,
  input  wire logic                  pb_power_down_i,
  input  wire logic                  pb_switcher_on_i,
  output logic [1:0]                 linear_reg_power_o,
  output logic [1:0]                 linear_reg_discharge_o,
  output logic                       switcher_group_on_o,
  output logic [2:0]                 switcher_burst_select_o,
  output logic                       switcher_group_good_out_o,
  output logic                       switcher_group_good_out_oe_o,
  output logic                       irq_o
);
  import repg_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  repg_sense_t s;
  repg_sense_t s_prev_reg;

  repg_sync #(
    .W ($bits(repg_sense_t))
  ) u_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .ce_i    (ce_i),
    .d_i     (sense_i),
    .q_o     (s)
  );

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      s_prev_reg <= SENSE_RST;
    end else if (ce_i) begin
      s_prev_reg <= s;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  repg_bus_state_t   bus_state_reg;
  logic              bus_take;
  logic              bus_commit;
  logic [31:0]       rd_mux;
  logic [LIN_N-1:0]  lin_en_reg;
  logic [LIN_N-1:0]  lin_on_reg;
  logic [SW_N-1:0]   burst_reg;
  logic              sw_on_reg;
  logic              pg_good_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_en_reg;

  // One request is taken from idle; waitrequest drops one cycle later for exactly one cycle.
  assign bus_take   = (avs_req_i.read | avs_req_i.write) && (bus_state_reg == BUS_IDLE);
  assign bus_commit = avs_req_i.write && (bus_state_reg == BUS_ACK);

  always_comb begin
    rd_mux = '0;
    unique case (avs_req_i.address)
      ADDR_CTRL: begin
        rd_mux[CTRL_LIN_LSB +: LIN_N] = lin_en_reg;
        rd_mux[CTRL_BRST_LSB +: SW_N] = burst_reg;
      end
      ADDR_STATUS: begin
        rd_mux[STAT_GOOD_LSB +: LIN_N] = s.linear_reg_good; // [RULE_05]
        rd_mux[STAT_ON_LSB +: LIN_N]   = lin_on_reg;
        rd_mux[STAT_SW_ON]             = sw_on_reg;
        rd_mux[STAT_SW_GOOD]           = pg_good_reg;
      end
      ADDR_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_reg;
      ADDR_IRQ_EN:   rd_mux[IRQ_W-1:0] = irq_en_reg;
      default:       rd_mux = '0;
    endcase
  end

  // The comparators are sampled only on the edge that takes a read, so the read-back
  // is a snapshot rather than a live view of a possibly chattering comparator.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      bus_state_reg     <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= RDATA_RST;
    end else if (ce_i) begin
      unique case (bus_state_reg)
        BUS_IDLE: begin
          if (bus_take) begin
            bus_state_reg     <= BUS_ACK;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= avs_req_i.read ? rd_mux : RDATA_RST; // [RULE_06]
          end
        end
        BUS_ACK: begin
          bus_state_reg     <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Linear regulators
  // ----------------------------------------------------------------
  logic lin_inhibit;

  assign lin_inhibit = s.system_supply_rail_low | s.logic_supply_rail_low | pb_power_down_i;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      lin_en_reg <= '0;
    end else if (ce_i) begin
      if (lin_inhibit) begin
        lin_en_reg <= '0; // [RULE_02] [RULE_03]
      end else if (bus_commit && avs_req_i.address == ADDR_CTRL) begin
        lin_en_reg <= avs_req_i.writedata[CTRL_LIN_LSB +: LIN_N]; // [RULE_01]
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      lin_on_reg             <= '0;
      linear_reg_power_o     <= '0;
      linear_reg_discharge_o <= '1;
    end else if (ce_i) begin
      lin_on_reg             <= lin_en_reg & {LIN_N{~lin_inhibit}}; // [RULE_01] [RULE_02]
      linear_reg_power_o     <= lin_en_reg & {LIN_N{~lin_inhibit}};
      linear_reg_discharge_o <= ~(lin_en_reg & {LIN_N{~lin_inhibit}}); // [RULE_04]
    end
  end

  // ----------------------------------------------------------------
  // Switchers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      burst_reg               <= '0;
      switcher_burst_select_o <= '0;
    end else if (ce_i && bus_commit && avs_req_i.address == ADDR_CTRL) begin
      burst_reg               <= avs_req_i.writedata[CTRL_BRST_LSB +: SW_N]; // [RULE_07]
      switcher_burst_select_o <= avs_req_i.writedata[CTRL_BRST_LSB +: SW_N];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sw_on_reg           <= 1'b0;
      switcher_group_on_o <= 1'b0;
    end else if (ce_i) begin
      sw_on_reg           <= pb_switcher_on_i & ~s.system_supply_rail_low; // [RULE_08] [RULE_09]
      switcher_group_on_o <= pb_switcher_on_i & ~s.system_supply_rail_low;
    end
  end

  // ----------------------------------------------------------------
  // Group power-good
  // ----------------------------------------------------------------
  logic all_good;
  logic tmr_done;
  logic pg_good_next;

  assign all_good     = sw_on_reg & (&s.switcher_above_92); // [RULE_10]
  assign pg_good_next = tmr_done & all_good; // [RULE_13]

  repg_pg_timer #(
    .DELAY (PG_DELAY_CYCLES)
  ) u_pg_timer (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .ce_i    (ce_i),
    .run_i   (all_good),
    .done_o  (tmr_done)
  );

  // The pin is only ever pulled low; the high level comes from the board pull-up.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      pg_good_reg                  <= 1'b0;
      switcher_group_good_out_o    <= 1'b0;
      switcher_group_good_out_oe_o <= 1'b1;
    end else if (ce_i) begin
      pg_good_reg                  <= pg_good_next; // [RULE_11]
      switcher_group_good_out_o    <= 1'b0;
      switcher_group_good_out_oe_o <= ~pg_good_next; // [RULE_12]
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_en_next;

  always_comb begin
    irq_ev               = '0;
    irq_ev[IRQ_SYS_UV]   = s.system_supply_rail_low & ~s_prev_reg.system_supply_rail_low;
    irq_ev[IRQ_LOGIC_UV] = s.logic_supply_rail_low & ~s_prev_reg.logic_supply_rail_low;
    irq_ev[IRQ_PG_RISE]  = pg_good_next & ~pg_good_reg;
    irq_ev[IRQ_PG_FALL]  = ~pg_good_next & pg_good_reg;
    irq_clr = (bus_commit && avs_req_i.address == ADDR_IRQ_CLR) ?
              avs_req_i.writedata[IRQ_W-1:0] : '0;
    irq_en_next = (bus_commit && avs_req_i.address == ADDR_IRQ_EN) ?
                  avs_req_i.writedata[IRQ_W-1:0] : irq_en_reg;
    // A new event beats a clear issued in the same cycle.
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
      irq_o        <= 1'b0;
    end else if (ce_i) begin
      irq_stat_reg <= irq_stat_next;
      irq_en_reg   <= irq_en_next;
      irq_o        <= |(irq_stat_next & irq_en_next);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] good_run_cnt;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      good_run_cnt <= '0;
    end else if (ce_i) begin
      if (!all_good) begin
        good_run_cnt <= '0;
      end else if (good_run_cnt != CNT_W'(PG_DELAY_CYCLES)) begin
        good_run_cnt <= good_run_cnt + CNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_status_read;
    ce_i && bus_take && avs_req_i.read && avs_req_i.address == ADDR_STATUS;
  endsequence

  sequence s_ctrl_write;
    ce_i && bus_commit && avs_req_i.address == ADDR_CTRL;
  endsequence

  AST_LIN_ON: assert property (ce_i && lin_en_reg[0] && !lin_inhibit |=> linear_reg_power_o[0]) // [RULE_01]
    else $error("first linear regulator not on while enabled");
  AST_LIN_OFF: assert property (ce_i && lin_inhibit |=> linear_reg_power_o == '0) // [RULE_02]
    else $error("linear regulator on while inhibited");
  AST_UVLO_BLOCK: assert property (ce_i && s.system_supply_rail_low |=> lin_en_reg == '0) // [RULE_03]
    else $error("enable accepted during lockout");
  AST_DISCHARGE: assert property (linear_reg_discharge_o == ~linear_reg_power_o) // [RULE_04]
    else $error("discharge not complementary to power");
  AST_GOOD_CAPTURE: assert property (s_status_read |=> !avs_waitrequest_o ##0
      avs_readdata_o[STAT_GOOD_LSB +: LIN_N] == $past(s.linear_reg_good)) // [RULE_05] [RULE_06]
    else $error("power-good read-back not the sampled value");
  AST_BURST: assert property (s_ctrl_write |=>
      switcher_burst_select_o == $past(avs_req_i.writedata[CTRL_BRST_LSB +: SW_N])) // [RULE_07]
    else $error("burst selects not taken from write");
  AST_SW_GROUP: assert property (ce_i |=> switcher_group_on_o == $past(pb_switcher_on_i &
      ~s.system_supply_rail_low)) // [RULE_08] [RULE_09]
    else $error("switcher group enable wrong");
  AST_PG_DROP: assert property (ce_i && !all_good |=> switcher_group_good_out_oe_o) // [RULE_10] [RULE_13]
    else $error("group good released without all switchers good");
  AST_PG_DELAY: assert property (pg_good_reg |-> good_run_cnt >= CNT_W'(PG_DELAY_CYCLES)) // [RULE_11]
    else $error("group good released before delay");
  AST_IRQ_LEVEL: assert property (irq_o == |(irq_stat_reg & irq_en_reg))
    else $error("interrupt output not matching enabled status");
  AST_PG_RELEASE: assert property (ce_i && tmr_done && all_good |=> // [RULE_10] [RULE_11]
      !switcher_group_good_out_oe_o)
    else $error("group good held low after the delay ran out");
  AST_PG_PIN_LOW: assert property (switcher_group_good_out_o == 1'b0) // [RULE_12]
    else $error("open-drain data not low");

endmodule

// file: verification/repg_sys_model.sv
// Far-side model: switcher feedback comparators and the pulled-up processor reset net.
`timescale 1ns/1ps
module repg_sys_model #(
  parameter int RAMP = 20
) (
  input  wire logic       clock_i,
  input  wire logic       group_on_i,
  input  wire logic [2:0] fail_i,
  input  wire logic       pg_i,
  input  wire logic       pg_oe_i,
  output logic [2:0]      above_92_o,
  output logic            cpu_nrst_o
);
  int ramp_reg = 0;
  // ----------------------------------------------------------------
  // Behaviour
  // ----------------------------------------------------------------
  // The ramp restarts whenever the group is off, as real outputs collapse.
  always_ff @(posedge clock_i) begin
    if (!group_on_i) ramp_reg <= 0;
    else if (ramp_reg < RAMP) ramp_reg <= ramp_reg + 1;
  end
  assign above_92_o = (ramp_reg == RAMP) ? ~fail_i : 3'h0;
  // The external pull-up sets the net high whenever the pin is not pulled low.
  assign cpu_nrst_o = pg_oe_i ? pg_i : 1'b1;
endmodule

// file: verification/tb.sv
// Self-checking bench for the regulator enable and power-good block.
`timescale 1ns/1ps
module tb;
  import repg_pkg::*;
  localparam int unsigned N = 8;
  logic          clock_i   = 1'b0;
  logic          nrst_i    = 1'b0;
  logic          ce_i      = 1'b1;
  repg_avs_req_t req       = '0;
  logic          sys_low   = 1'b0;
  logic          logic_low = 1'b0;
  logic          pb_down   = 1'b0;
  logic          pb_on     = 1'b0;
  logic [1:0]    lin_good  = 2'h0;
  logic [2:0]    fail      = 3'h0;
  logic [31:0]   seed      = 32'h1a08d5cc;
  logic [31:0]   rdata, d;
  logic [2:0]    above, burst;
  logic [1:0]    pwr, dis;
  logic          wreq, gon, pg, pg_oe, irq, cpu_nrst;
  repg_sense_t   sense;
  int            bad_count = 0;
  int            checked   = 0;
  int            cnt;

  assign sense = {sys_low, logic_low, lin_good, above};
  always #20 clock_i = ~clock_i;

  repg_top #(.PG_DELAY_CYCLES(N)) DUT (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .sense_i(sense),
    .pb_power_down_i(pb_down), .pb_switcher_on_i(pb_on), .linear_reg_power_o(pwr),
    .linear_reg_discharge_o(dis), .switcher_group_on_o(gon), .switcher_burst_select_o(burst),
    .switcher_group_good_out_o(pg), .switcher_group_good_out_oe_o(pg_oe), .irq_o(irq));
  repg_sys_model MODEL (
    .clock_i(clock_i), .group_on_i(gon), .fail_i(fail), .pg_i(pg), .pg_oe_i(pg_oe),
    .above_92_o(above), .cpu_nrst_o(cpu_nrst));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ctrl_exp(input logic [31:0] v);
    return {25'h0, v[6:4], 2'h0, v[1:0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // The request stays up until waitrequest is sampled low or 50 cycles pass; a timeout is counted as a failure.
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clock_i);
    req <= '{read: !is_wr, write: is_wr, address: a, writedata: wd};
    do begin
      @(posedge clock_i);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    rd = rdata;
    req <= '0;
    if (k >= 50) cmp(32'h1, 32'h0);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    cmp(x, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_until(input int sel, input logic v, output int n);
    n = 0;
    while ((sel == 0 ? pg_oe : &above) !== v && n < 200) begin
      @(posedge clock_i);
      #1;
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("Counts: checked=%0d bad=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    bad_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    wait_cyc(1);
    cmp({pwr, dis, gon, burst, pg, pg_oe, irq}, 11'h182);
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(5'h14, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = xs();
      if (i == 0) d[1:0] = 2'h3;
      if (i == 1) d[1:0] = 2'h0;
      wr(ADDR_CTRL, d);
      wait_cyc(1);
      cmp({pwr, dis}, {d[1:0], ~d[1:0]});
      cmp(burst, d[6:4]);
      rd_chk(ADDR_CTRL, ctrl_exp(d));
    end
    $display("test enables done");
    // Each inhibit in turn: lockout, logic undervoltage, power-down state.
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CTRL, 32'h3);
      @(posedge clock_i);
      {sys_low, logic_low, pb_down} <= 3'h4 >> k;
      wait_cyc(8);
      cmp({pwr, dis}, 4'h3);
      wr(ADDR_CTRL, 32'h3);
      wait_cyc(2);
      cmp(pwr, 2'h0);
      @(posedge clock_i);
      {sys_low, logic_low, pb_down} <= 3'h0;
      wait_cyc(8);
      rd_chk(ADDR_CTRL, 32'h0);
    end
    rd_chk(ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_IRQ_CLR, 32'h3);
    rd_chk(ADDR_IRQ_STAT, 32'h0);
    wr(5'h14, 32'h7f);
    wr(ADDR_STATUS, 32'hff);
    rd_chk(ADDR_CTRL, 32'h0);
    $display("test inhibits done");
    wr(ADDR_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      lin_good <= i[1:0];
      wait_cyc(6);
      rd_chk(ADDR_STATUS, {28'h3, i[1:0]});
      @(posedge clock_i);
      lin_good <= ~i[1:0];
      wait_cyc(6);
      cmp(rdata, {28'h3, i[1:0]});
    end
    $display("test status done");
    @(posedge clock_i);
    pb_on <= 1'b1;
    wait_cyc(8);
    cmp({gon, pg_oe}, 2'h3);
    wait_until(1, 1'b1, cnt);
    wait_until(0, 1'b0, cnt);
    cmp_rng(cnt, N + 2, N + 6);
    cmp({pg, cpu_nrst}, 2'h1);
    rd_chk(ADDR_STATUS, {26'h0, 2'h3, 2'h3, lin_good});
    rd_chk(ADDR_IRQ_STAT, 32'h4);
    cmp(irq, 1'b0);
    wr(ADDR_IRQ_EN, 32'h4);
    wait_cyc(1);
    cmp(irq, 1'b1);
    wr(ADDR_IRQ_CLR, 32'h4);
    wait_cyc(1);
    cmp(irq, 1'b0);
    wr(ADDR_IRQ_EN, 32'h8);
    for (int j = 0; j < 3; j++) begin
      @(posedge clock_i);
      fail <= 3'h1 << j;
      wait_until(0, 1'b1, cnt);
      cmp_rng(cnt, 1, 7);
      cmp(cpu_nrst, 1'b0);
      wait_cyc(2);
      cmp(irq, 1'b1);
      wr(ADDR_IRQ_CLR, 32'hc);
      wait_cyc(1);
      cmp(irq, 1'b0);
      @(posedge clock_i);
      fail <= 3'h0;
      wait_until(0, 1'b0, cnt);
      cmp_rng(cnt, N + 2, N + 6);
    end
    $display("test power-good done");
    @(posedge clock_i);
    sys_low <= 1'b1;
    wait_cyc(7);
    cmp({gon, pg_oe, pwr}, 4'h4);
    @(posedge clock_i);
    sys_low <= 1'b0;
    wait_cyc(7);
    cmp(gon, 1'b1);
    @(posedge clock_i);
    pb_on <= 1'b0;
    wait_cyc(7);
    cmp({gon, pg_oe}, 2'h1);
    // A low clock enable must freeze the group enable even though the sequencer asks for it.
    @(posedge clock_i);
    ce_i  <= 1'b0;
    pb_on <= 1'b1;
    wait_cyc(4);
    cmp(gon, 1'b0);
    @(posedge clock_i);
    ce_i <= 1'b1;
    wait_cyc(2);
    cmp(gon, 1'b1);
    $display("test lockout done");
    wrap_up();
  end
endmodule
